/* hdl/dmc_ctrl.sv */
`timescale 1ns/1ps
// Mode control and protection for the twelve-channel driver
module dmc_ctrl
  import dmc_pkg::*;
#(
  parameter int NCH = CH_COUNT
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Pins and analog status, asynchronous
  input wire logic i_enable,
  input wire logic i_supply_core_ok,
  input wire logic i_analog_supply_rail_ok,
  input wire logic i_select_low_port,
  input wire logic i_select_high_port,
  input wire logic [NCH-1:0] i_overload,
  input wire logic [NCH-1:0] i_overtemp,
  input wire logic [NCH-1:0] i_openload,
  // Serial decoder, same clock
  input wire logic i_frame_error,
  // Driver controls
  output logic [NCH-1:0] o_drive_on,
  output logic [NCH-1:0] o_diag_sink_en,
  output logic o_low_iq,
  output logic o_global_standby,
  output logic o_undervoltage_lockout_state,
  output logic o_irq
);

  // ==========================================================
  // Pin synchronisers
  localparam int SW = 3 * NCH + 5;
  localparam logic [SW-1:0] SYNC_RST = {2'h3, {(SW - 2){1'b0}}};

  logic [SW-1:0] sync_raw;
  logic [SW-1:0] sync_out;
  logic [NCH-1:0] ovl_s;
  logic [NCH-1:0] ot_s;
  logic [NCH-1:0] open_s;
  logic en_s;
  logic core_ok_s;
  logic ana_ok_s;
  logic sel_lo_s;
  logic sel_hi_s;

  // Enable is sampled once per 8 ns, far finer than a valid pulse
  assign sync_raw = {i_select_high_port, i_select_low_port,
                     i_analog_supply_rail_ok, i_supply_core_ok, i_enable,
                     i_openload, i_overtemp, i_overload};
  assign ovl_s = sync_out[NCH-1:0];
  assign ot_s = sync_out[2*NCH-1:NCH];
  assign open_s = sync_out[3*NCH-1:2*NCH];
  assign en_s = sync_out[3*NCH];
  assign core_ok_s = sync_out[3*NCH+1];
  assign ana_ok_s = sync_out[3*NCH+2];
  assign sel_lo_s = sync_out[3*NCH+3];
  assign sel_hi_s = sync_out[3*NCH+4];

  dmc_sync #(
    .W(SW),
    .RST_VAL(SYNC_RST)
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_async(sync_raw),
    .o_sync(sync_out)
  );

  // ==========================================================
  // Operating state
  dmc_state_e state_q;
  dmc_state_e state_d;
  logic supplies_ok;
  logic run;

  assign supplies_ok = core_ok_s & ana_ok_s;
  assign run = (state_q == ST_RUN);

  // Supply loss overrides everything, then the enable pin
  always_comb
  begin
    state_d = ST_UNDERVOLTAGE_LOCKOUT_STATE;
    case (state_q)
      ST_UNDERVOLTAGE_LOCKOUT_STATE:
        if (supplies_ok)
          state_d = en_s ? ST_RUN : ST_SLEEP;
      ST_SLEEP, ST_RUN:
        if (!supplies_ok)
          state_d = ST_UNDERVOLTAGE_LOCKOUT_STATE;
        else if (!en_s)
          state_d = ST_SLEEP;
        else
          state_d = ST_RUN;
      default:
        state_d = ST_UNDERVOLTAGE_LOCKOUT_STATE;
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      state_q <= ST_UNDERVOLTAGE_LOCKOUT_STATE;
    else
      state_q <= state_d;
  end

  // ==========================================================
  // APB decode
  logic apb_setup;
  logic apb_access;
  logic apb_wr;
  logic hit_cmd;
  logic hit_fault;
  logic hit_diag;
  logic hit_mode;
  logic hit_irq_st;
  logic hit_irq_clr;
  logic hit_irq_en;
  logic hit_any;
  logic wr_cmd;
  logic [31:0] rd_mux;

  assign apb_setup = i_psel & ~i_penable;
  assign apb_access = i_psel & i_penable;
  assign apb_wr = apb_access & i_pwrite;
  assign hit_cmd = (i_paddr == ADDR_CMD);
  assign hit_fault = (i_paddr == ADDR_FAULT);
  assign hit_diag = (i_paddr == ADDR_DIAG);
  assign hit_mode = (i_paddr == ADDR_MODE);
  assign hit_irq_st = (i_paddr == ADDR_IRQ_ST);
  assign hit_irq_clr = (i_paddr == ADDR_IRQ_CLR);
  assign hit_irq_en = (i_paddr == ADDR_IRQ_EN);
  assign hit_any = hit_cmd | hit_fault | hit_diag | hit_mode |
                   hit_irq_st | hit_irq_clr | hit_irq_en;
  // Commands are only taken while awake and powered
  assign wr_cmd = apb_wr & hit_cmd & run;
  assign o_pready = 1'b1;
  assign o_pslverr = apb_access & ~hit_any;

  // ==========================================================
  // Command register and power-up variant
  logic [CMD_W-1:0] cmd_q;
  logic pu_q;

  // Sleep and lockout both force the power-on values
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst || !run)
    begin
      cmd_q <= CMD_RESET;
      pu_q <= 1'b1;
    end
    else if (wr_cmd)
    begin
      cmd_q <= i_pwdata[CMD_W-1:0];
      pu_q <= 1'b0;
    end
  end

  // ==========================================================
  // Per-channel decode and fault latches
  logic [NCH-1:0] ovl_q;
  logic [NCH-1:0] ot_q;
  logic [NCH-1:0] open_q;
  logic [NCH-1:0] ovl_set;
  logic [NCH-1:0] ot_set;
  logic [NCH-1:0] open_set;
  logic [NCH-1:0] on_mask;
  logic [NCH-1:0] off_mask;
  logic [NCH-1:0] stby_mask;
  logic [NCH-1:0] wr_stby;
  logic [NCH-1:0] drive_d;
  logic [NCH-1:0] sink_d;
  logic stby_clr;

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      assign on_mask[g] = (cmd_q[2*g+1:2*g] == CMD_ON);
      assign off_mask[g] = (cmd_q[2*g+1:2*g] == CMD_OFF);
      assign stby_mask[g] = (cmd_q[2*g+1:2*g] == CMD_STBY);
      assign wr_stby[g] = wr_cmd & (i_pwdata[2*g+1:2*g] == CMD_STBY);
      // Over-load only counts while the channel is driving
      assign ovl_set[g] = run & o_drive_on[g] & ovl_s[g];
      // Each sensor touches its own channel only
      assign ot_set[g] = run & ot_s[g];
      assign open_set[g] = run & o_diag_sink_en[g] & open_s[g];
      // Latched channel ignores a repeated on command
      assign drive_d[g] = run & on_mask[g] & ~ovl_q[g] & ~ot_q[g] &
                          ~ovl_set[g] & ~ot_set[g];
      // Sink only in the normal off variant
      assign sink_d[g] = run & off_mask[g] & ~pu_q;
    end
  endgenerate

  assign stby_clr = |wr_stby;

  // New fault wins over a standby clear in the same cycle
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst || !run)
    begin
      ovl_q <= '0;
      ot_q <= '0;
      open_q <= '0;
    end
    else
    begin
      ovl_q <= ovl_set | (ovl_q & {NCH{~stby_clr}});
      ot_q <= ot_set | (ot_q & {NCH{~stby_clr}});
      open_q <= open_set | (open_q & {NCH{~stby_clr}});
    end
  end

  // ==========================================================
  // Drive, sink and global standby outputs registered so no decode glitch reaches a gate; low-Iq and lockout decode state_q
  logic all_stby;
  logic all_off;

  assign all_stby = &stby_mask;
  assign all_off = &off_mask;

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_drive_on <= '0;
      o_diag_sink_en <= '0;
      o_global_standby <= 1'b0;
    end
    else
    begin
      o_drive_on <= drive_d;
      o_diag_sink_en <= sink_d;
      o_global_standby <= run & all_stby;
    end
  end

  assign o_low_iq = (state_q == ST_SLEEP);
  assign o_undervoltage_lockout_state = (state_q == ST_UNDERVOLTAGE_LOCKOUT_STATE);

  // ==========================================================
  // Frame error flag, updated when both selects are high again
  logic both_hi;
  logic both_hi_q;
  logic frame_end;
  logic ferr_seen_q;
  logic ferr_flag_q;

  // Relies on the idle gap, far above two sampling periods
  assign both_hi = sel_lo_s & sel_hi_s;
  assign frame_end = both_hi & ~both_hi_q;

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst || !run)
    begin
      both_hi_q <= 1'b1;
      ferr_seen_q <= 1'b0;
      ferr_flag_q <= 1'b1;
    end
    else
    begin
      both_hi_q <= both_hi;
      ferr_seen_q <= ~frame_end & (ferr_seen_q | i_frame_error);
      if (frame_end)
        ferr_flag_q <= ferr_seen_q | i_frame_error;
    end
  end

  // ==========================================================
  // Interrupts
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] irq_st_q;
  logic [IRQ_W-1:0] irq_en_q;
  logic [IRQ_W-1:0] irq_clr;

  assign irq_ev[IRQ_OVL] = |ovl_set;
  assign irq_ev[IRQ_OT] = |ot_set;
  assign irq_ev[IRQ_OPEN] = |open_set;
  assign irq_ev[IRQ_UNDERVOLTAGE_LOCKOUT_STATE] = (state_d == ST_UNDERVOLTAGE_LOCKOUT_STATE) & (state_q != ST_UNDERVOLTAGE_LOCKOUT_STATE);
  assign irq_ev[IRQ_FERR] = frame_end & (ferr_seen_q | i_frame_error);
  assign irq_clr = (apb_wr & hit_irq_clr) ? i_pwdata[IRQ_W-1:0] : '0;
  assign o_irq = |(irq_st_q & irq_en_q);

  // Event beats a clear arriving in the same cycle
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      irq_st_q <= '0;
      irq_en_q <= '0;
    end
    else
    begin
      irq_st_q <= irq_ev | (irq_st_q & ~irq_clr);
      if (apb_wr & hit_irq_en)
        irq_en_q <= i_pwdata[IRQ_W-1:0];
    end
  end

  // ==========================================================
  // Read data, captured in the setup cycle
  logic [31:0] mode_word;
  logic [31:0] fault_word;
  logic [31:0] diag_word;

  assign mode_word = 32'(run) << MODE_RUN |
                     32'(o_undervoltage_lockout_state) << MODE_UNDERVOLTAGE_LOCKOUT_STATE |
                     32'(o_low_iq) << MODE_LOWIQ |
                     32'(run & all_stby) << MODE_GSTBY |
                     32'(run & all_off) << MODE_GOFF |
                     32'(pu_q) << MODE_PWRUP;
  // Three separate flags per channel
  assign fault_word = 32'(ovl_q) | (32'(ot_q) << FLT_OT_LSB);
  assign diag_word = 32'(open_q) | (32'(ferr_flag_q) << DIAG_FERR_BIT);
  assign rd_mux = hit_cmd ? 32'(cmd_q) :
                  hit_fault ? fault_word :
                  hit_diag ? diag_word :
                  hit_mode ? mode_word :
                  hit_irq_st ? 32'(irq_st_q) :
                  hit_irq_en ? 32'(irq_en_q) : 32'h0000_0000;

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      o_prdata <= '0;
    else if (apb_setup && !i_pwrite)
      o_prdata <= rd_mux;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_wake;
    !run ##1 run;
  endsequence

  sequence s_stby_write;
    wr_cmd && stby_clr;
  endsequence

  a_decode_on: assert property (
    run |=> (o_drive_on & ~$past(on_mask)) == '0)
    else $error("driver output does not follow on command");

  a_stby_clears: assert property (
    s_stby_write |=> (ovl_q & ~$past(ovl_set)) == '0)
    else $error("standby write left a latched fault");

  a_stby_quiet: assert property (
    run && all_stby |=> (o_drive_on | o_diag_sink_en) == '0)
    else $error("standby channel drives or sinks");

  a_global_stby: assert property (
    run && all_stby && $stable(cmd_q) |=> o_global_standby)
    else $error("global standby not flagged");

  a_pwrup_nosink: assert property (
    pu_q |=> o_diag_sink_en == '0)
    else $error("sink enabled in power-up off");

  a_ovl_latched: assert property (
    ovl_q != '0 |-> (o_drive_on & ovl_q & $past(ovl_q)) == '0)
    else $error("overloaded channel still on");

  a_undervoltage_lockout_state_off: assert property (
    !supplies_ok |-> ##[1:2] o_undervoltage_lockout_state ##1
    o_drive_on == '0)
    else $error("outputs not off in lockout");

  a_wake_values: assert property (
    s_wake |-> cmd_q == CMD_RESET && ovl_q == '0 && ot_q == '0 &&
    ferr_flag_q && pu_q)
    else $error("wrong values on wake");

  a_sleep_clear: assert property (
    o_low_iq |=> cmd_q == CMD_RESET && o_drive_on == '0)
    else $error("registers kept during sleep");

  a_irq_sticky: assert property (
    irq_st_q[IRQ_OVL] && !(apb_wr && hit_irq_clr) |=>
    irq_st_q[IRQ_OVL])
    else $error("sticky status bit lost");

endmodule : dmc_ctrl

/* hdl/dmc_pkg.sv */
// Functional notes
// - Per-channel code: 11 off, 10 on, 00 standby
// - Any standby write clears all latched faults
// - Standby channel: output off, no diagnostic sink
// - All channels standby gives global standby state
// - Off: output off, sink only outside power-up variant
// - Over-load switches channel off and latches it
// - Either supply low: all off, lockout state
// - Leaving lockout: all off, no diagnostic sink
// - Reset values: commands all ones, frame flag one
// - Recovery clears fault storage, global off state
// - Other global off entries enable diagnostic sink
// - Enable low holds lowest consumption state
// - Over-temperature acts on its own channel only
// - Enable low clears registers and driver logic; interrupt status and enable registers are kept
package dmc_pkg;

  // ==========================================================
  // Channel commands
  localparam int CH_COUNT = 12;
  localparam logic [1:0] CMD_OFF = 2'h3;
  localparam logic [1:0] CMD_ON = 2'h2;
  localparam logic [1:0] CMD_STBY = 2'h0;
  localparam logic [23:0] CMD_RESET = 24'hffffff;
  localparam int CMD_W = 24;

  // ==========================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_FAULT = 8'h04;
  localparam logic [7:0] ADDR_DIAG = 8'h08;
  localparam logic [7:0] ADDR_MODE = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_ST = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h14;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h18;

  // ==========================================================
  // Field positions
  localparam int FLT_OT_LSB = 16;
  localparam int DIAG_FERR_BIT = 16;
  localparam int MODE_RUN = 0;
  localparam int MODE_UNDERVOLTAGE_LOCKOUT_STATE = 1;
  localparam int MODE_LOWIQ = 2;
  localparam int MODE_GSTBY = 3;
  localparam int MODE_GOFF = 4;
  localparam int MODE_PWRUP = 5;
  localparam int IRQ_OVL = 0;
  localparam int IRQ_OT = 1;
  localparam int IRQ_OPEN = 2;
  localparam int IRQ_UNDERVOLTAGE_LOCKOUT_STATE = 3;
  localparam int IRQ_FERR = 4;
  localparam int IRQ_W = 5;

  // ==========================================================
  // Operating states
  typedef enum logic [2:0]
  {
    ST_SLEEP = 3'h1,
    ST_UNDERVOLTAGE_LOCKOUT_STATE = 3'h2,
    ST_RUN = 3'h4
  } dmc_state_e;

endpackage : dmc_pkg

/* hdl/dmc_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for a bundle of pin levels
module dmc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Levels
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      meta_q <= RST_VAL;
      o_sync <= RST_VAL;
    end
    else
    begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule : dmc_sync

/* dv/dmc_mcu_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Serial master stand-in: frames on the two selects
module dmc_mcu_model (
  // Clock
  input wire logic i_core_clk,
  // Selects, active low, and decoder error pulse
  output logic o_select_low_port,
  output logic o_select_high_port,
  output logic o_frame_error
);

  // Selects idle high like their pull-ups
  initial
  begin
    o_select_low_port = 1'b1;
    o_select_high_port = 1'b1;
    o_frame_error = 1'b0;
  end

  // One frame on either select, optional error pulse inside it
  task automatic frame(input logic err, input logic hi);
    @(posedge i_core_clk);
    if (hi)
      o_select_high_port <= 1'b0;
    else
      o_select_low_port <= 1'b0;
    repeat (24) @(posedge i_core_clk);
    o_frame_error <= err;
    @(posedge i_core_clk);
    o_frame_error <= 1'b0;
    o_select_low_port <= 1'b1;
    o_select_high_port <= 1'b1;
    // 188 clocks keeps both selects high past 1.5 us
    repeat (188) @(posedge i_core_clk);
  endtask : frame

endmodule : dmc_mcu_model

/* dv/tb.sv */
`timescale 1ns/1ps
`define CHK(a, e, m) begin tests_run++; if ((a) !== (e)) begin \
  n_mismatch++; $display("BAD %0t %s", $time, m); end end
// ==========================================================
// Self-checking bench for the mode control block
module tb;
  import dmc_pkg::*;

  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  logic i_enable = 1'b1;
  logic i_supply_core_ok = 1'b1;
  logic i_analog_supply_rail_ok = 1'b1;
  logic [11:0] i_overload = 12'h000;
  logic [11:0] i_overtemp = 12'h000;
  logic [11:0] i_openload = 12'h000;
  logic sel_lo, sel_hi, ferr, o_pready, o_pslverr, o_irq;
  logic o_low_iq, o_global_standby, o_undervoltage_lockout_state;
  logic [31:0] o_prdata;
  logic [11:0] o_drive_on, o_diag_sink_en;
  int n_mismatch = 0;
  int tests_run = 0;

  // Clock at 125 MHz
  always #4 i_core_clk = ~i_core_clk;

  dmc_mcu_model dmc_mcu_model_inst (.i_core_clk(i_core_clk),
    .o_select_low_port(sel_lo), .o_select_high_port(sel_hi),
    .o_frame_error(ferr));

  dmc_ctrl dmc_ctrl_inst (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_enable(i_enable),
    .i_supply_core_ok(i_supply_core_ok),
    .i_analog_supply_rail_ok(i_analog_supply_rail_ok),
    .i_select_low_port(sel_lo), .i_select_high_port(sel_hi),
    .i_overload(i_overload), .i_overtemp(i_overtemp),
    .i_openload(i_openload), .i_frame_error(ferr),
    .o_drive_on(o_drive_on), .o_diag_sink_en(o_diag_sink_en),
    .o_low_iq(o_low_iq), .o_global_standby(o_global_standby),
    .o_undervoltage_lockout_state(o_undervoltage_lockout_state),
    .o_irq(o_irq));

  task automatic wcyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask : wcyc

  // One APB transfer; waits on pready, only the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output logic err);
    @(posedge i_core_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    @(posedge i_core_clk);
    while (o_pready !== 1'b1)
    begin
      @(posedge i_core_clk);
    end
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, a, d, rd, e);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x,
    input string m);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 32'h0, rd, e);
    `CHK(rd, x, m)
  endtask : rd_chk

  // Single closing point for every path
  task automatic stop_test;
    $display("mismatches %0d of %0d compares", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // Watchdog: the tests need about 55 us
  initial
  begin
    #300000;
    n_mismatch++;
    stop_test;
  end

  initial
  begin
    logic [31:0] rd;
    logic e;
    wcyc(20);
    i_rst <= 1'b0;
    wcyc(8);
    rd_chk(ADDR_CMD, {8'h00, CMD_RESET}, "cmd reset");
    rd_chk(ADDR_FAULT, 32'h0, "fault reset");
    rd_chk(ADDR_DIAG, 32'h1 << DIAG_FERR_BIT, "diag reset");
    // Run, global off and power-up variant
    rd_chk(ADDR_MODE, 32'h31, "mode reset");
    `CHK(o_diag_sink_en, 12'h000, "power-up sink")
    apb(1'b0, 8'h1c, 32'h0, rd, e);
    `CHK(e, 1'b1, "unmapped error")
    $display("test reset done");
    // Ch0 on, ch1 standby, rest off in normal variant
    wr(ADDR_CMD, 32'h00fffff2);
    wcyc(4);
    `CHK(o_drive_on, 12'h001, "decode on")
    `CHK(o_diag_sink_en, 12'hffc, "sink off/stby")
    $display("test decode done");
    // Over-load on ch0, interrupt masked at first
    i_overload <= 12'h001;
    wcyc(6);
    i_overload <= 12'h000;
    `CHK(o_drive_on, 12'h000, "overload off")
    `CHK(o_irq, 1'b0, "irq masked")
    rd_chk(ADDR_FAULT, 32'h1, "overload flag");
    wr(ADDR_IRQ_EN, 32'h1 << IRQ_OVL);
    wcyc(2);
    `CHK(o_irq, 1'b1, "irq raised")
    wr(ADDR_IRQ_CLR, 32'h1 << IRQ_OVL);
    wcyc(2);
    `CHK(o_irq, 1'b0, "irq cleared")
    wr(ADDR_CMD, 32'h00fffffe);
    wcyc(4);
    `CHK(o_drive_on, 12'h000, "stays latched")
    $display("test overload done");
    // All standby clears faults
    wr(ADDR_CMD, 32'h0);
    wcyc(4);
    `CHK(o_global_standby, 1'b1, "global standby")
    `CHK(o_diag_sink_en, 12'h000, "standby sink")
    rd_chk(ADDR_FAULT, 32'h0, "standby clears");
    $display("test standby done");
    // Over-temperature on ch1 leaves ch0 running
    wr(ADDR_CMD, 32'h00fffffa);
    wcyc(4);
    `CHK(o_drive_on, 12'h003, "two on")
    i_overtemp <= 12'h002;
    wcyc(6);
    i_overtemp <= 12'h000;
    `CHK(o_drive_on, 12'h001, "thermal own ch")
    rd_chk(ADDR_FAULT, 32'h1 << (FLT_OT_LSB + 1), "ot flag");
    $display("test thermal done");
    // Open load on ch5 plus frame error flag
    i_openload <= 12'h020;
    wcyc(6);
    i_openload <= 12'h000;
    // Clean frame first, so the flag must fall from its reset value
    dmc_mcu_model_inst.frame(1'b0, 1'b1);
    rd_chk(ADDR_DIAG, 32'h20, "ferr cleared");
    dmc_mcu_model_inst.frame(1'b1, 1'b0);
    rd_chk(ADDR_DIAG, 32'h10020, "open+ferr");
    $display("test diag done");
    // Sleep held past 50 us clears commands and flags, not interrupt status
    i_enable <= 1'b0;
    wcyc(6260);
    `CHK(o_low_iq, 1'b1, "low iq")
    `CHK(o_drive_on, 12'h000, "sleep off")
    i_enable <= 1'b1;
    wcyc(8);
    rd_chk(ADDR_CMD, {8'h00, CMD_RESET}, "sleep cmd");
    rd_chk(ADDR_DIAG, 32'h1 << DIAG_FERR_BIT, "sleep diag");
    $display("test sleep done");
    // Each supply in turn drops out
    for (int k = 0; k < 2; k++)
    begin
      wr(ADDR_CMD, 32'h00fffffe);
      wcyc(4);
      if (k == 0)
        i_supply_core_ok <= 1'b0;
      else
        i_analog_supply_rail_ok <= 1'b0;
      wcyc(6);
      `CHK(o_undervoltage_lockout_state, 1'b1, "lockout")
      `CHK(o_drive_on, 12'h000, "lockout off")
      i_supply_core_ok <= 1'b1;
      i_analog_supply_rail_ok <= 1'b1;
      wcyc(8);
      `CHK(o_undervoltage_lockout_state, 1'b0, "recover")
      `CHK(o_diag_sink_en, 12'h000, "recover sink")
      rd_chk(ADDR_CMD, {8'h00, CMD_RESET}, "recover cmd");
    end
    // Thermal, open-load, lockout and frame error events all sticky
    rd_chk(ADDR_IRQ_ST, 32'h1e, "irq status");
    $display("test lockout done");
    stop_test;
  end

endmodule : tb
